// ==== src/sfc_front_end.sv ====
// Serial flash command front end: link decoder on the serial clock, status and
// write control on mclk. Assumes the memory core answers reads on the serial clock.
`timescale 1ns/100ps
`default_nettype none

module sfc_front_end
  import sfc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART_ID  = 8'ha5, // Arbitrary value.
  parameter logic [7:0] JID_TYPE = 8'h3c, // Arbitrary value.
  parameter logic [7:0] JID_CAP  = 8'hc3  // Arbitrary value.
)
(
  // System side
  input  wire logic        mclk,
  input  wire logic        ce,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        sck,
  input  wire logic        select_n,
  input  wire logic        serial_in,
  input  wire logic        write_protect_n,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Memory core
  output logic [19:0]      mem_rd_addr,
  input  wire logic [7:0]  mem_rd_data,
  output var sfc_op_s      mem_op,
  output logic             mem_op_start,
  input  wire logic        mem_op_done
);

  sfc_link_s         l;
  sfc_link_s         next_l;
  sfc_tx_s           t;
  sfc_tx_s           next_t;
  sfc_core_s         c;
  sfc_core_s         next_c;
  logic              in_frame;
  logic [1:0]        rst_pipe;
  logic              rst_n_s;
  logic [SYNC_W-1:0] status_x;
  logic              l_first;
  logic [2:0]        l_bits;
  logic [2:0]        l_bytes;
  sfc_phase_e        l_phase;
  logic [7:0]        l_byte;
  logic [7:0]        tx_byte;
  logic              rb_mode;
  logic              frame_end;
  logic              one;
  logic [19:0]       c_addr;
  logic              want;
  sfc_kind_e         want_kind;
  logic [19:0]       want_addr;
  logic [2:0]        want_len;
  logic              blocked;
  logic              ok_aai_hit;

  function automatic logic prot_hit(input logic [2:0] lvl, input logic [19:0] a);
    case (lvl)
      LVL_OFF: return 1'b0;
      LVL_16:  return a >= FLOOR_16;
      LVL_8:   return a >= FLOOR_8;
      LVL_4:   return a >= FLOOR_4;
      LVL_2:   return a >= FLOOR_2;
      default: return 1'b1;
    endcase
  endfunction : prot_hit

  // Next phase chosen when the opcode byte completes.
  function automatic sfc_phase_e first_phase(input logic [7:0] op, input logic busy,
                                             input logic auto_on);
    if (busy && op != OP_STATUS_READ)
      return P_IGNORE;
    if (auto_on && op != OP_AUTO_INC && op != OP_WR_DIS && op != OP_STATUS_READ)
      return P_IGNORE;
    case (op)
      OP_READ, OP_FAST_READ, OP_ID_A, OP_ID_B, OP_PROG, OP_SECT, OP_BLK32, OP_BLK64:
        return P_ADDR;
      OP_AUTO_INC:
        return auto_on ? P_IN : P_ADDR;
      OP_STATUS_READ:
        return P_OUT_ST;
      OP_JEDEC_ID:
        return P_OUT_JID;
      OP_STATUS_WRITE, OP_WR_EN, OP_WR_DIS, OP_UNLOCK, OP_BUSY_ON, OP_BUSY_OFF,
      OP_CHIP_A, OP_CHIP_B:
        return P_IN;
      default:
        return P_IGNORE;
    endcase
  endfunction : first_phase

  // Status as seen by software; bit positions follow the ST_ constants.
  assign status_x = {c.busy_out, c.protect_lock, c.auto_inc, c.level, c.write_latch, c.busy};

  // A frame starts at the first rising clock edge after select_n falls.
  always_ff @(posedge sck or posedge select_n)
  begin
    if (select_n)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end

  always_comb
  begin
    next_l  = l;
    l_first = !in_frame;
    l_bits  = l_first ? BIT_FIRST : l.bit_cnt;
    l_bytes = l_first ? LEN_ZERO : l.byte_cnt;
    l_phase = l_first ? P_OP : l.phase;
    l_byte  = {l.shreg, serial_in};
    next_l.st_meta  = status_x;
    next_l.st_sync  = l.st_meta;
    if (l_first)
      next_l.frame_tog = !l.frame_tog;
    next_l.shreg    = l_byte[TX_MSB-1:0];
    next_l.bit_cnt  = l_bits + BIT_STEP;
    next_l.byte_cnt = l_bytes;
    next_l.phase    = l_phase;
    if (l_bits == BIT_LAST)
    begin
      if (l_bytes != LEN_MAX)
        next_l.byte_cnt = l_bytes + LEN_ONE;
      case (l_phase)
        P_OP:
        begin
          next_l.opcode  = l_byte;
          next_l.jid_idx = JID_FIRST;
          next_l.phase   = first_phase(l_byte, l.st_sync[ST_BUSY], l.st_sync[ST_AUTO]);
        end
        P_ADDR:
        begin
          next_l.addr = {l.addr[15:0], l_byte};
          if (l_bytes == ADDR_LAST_BYTE)
          begin
            next_l.rd_addr = {l.addr[11:0], l_byte};
            case (l.opcode)
              OP_READ:          next_l.phase = P_OUT_MEM;
              OP_FAST_READ:     next_l.phase = P_DUMMY;
              OP_ID_A, OP_ID_B: next_l.phase = P_OUT_ID;
              default:          next_l.phase = P_IN;
            endcase
          end
        end
        P_DUMMY:
          next_l.phase = P_OUT_MEM;
        P_IN:
        begin
          next_l.d0 = l.d1;
          next_l.d1 = l_byte;
        end
        P_OUT_MEM:
          next_l.rd_addr = l.rd_addr + ADDR_STEP;
        P_OUT_JID:
          next_l.jid_idx = (l.jid_idx == JID_LAST) ? JID_FIRST : l.jid_idx + JID_STEP;
        default:
          next_l.phase = l_phase;
      endcase
    end
  end

  // Edges while deselected are ignored, so the master may park the clock at
  // either level between frames without disturbing the frame toggle.
  always_ff @(posedge sck or negedge nrst)
  begin
    if (!nrst)
      l <= '0;
    else if (!select_n)
      l <= next_l;
  end

  // Output shifter on the falling edge, one byte loaded per byte boundary.
  always_comb
  begin
    next_t  = t;
    rb_mode = l.st_sync[SY_BUSY_OUT] && l.st_sync[ST_AUTO];
    case (l.phase)
      P_OUT_MEM: tx_byte = mem_rd_data;
      P_OUT_ST:  tx_byte = l.st_sync[ST_LOCK:ST_BUSY];
      P_OUT_ID:  tx_byte = l.addr[0] ? PART_ID : MAKER_ID;
      P_OUT_JID:
      begin
        case (l.jid_idx)
          JID_FIRST: tx_byte = MAKER_ID;
          JID_MID:   tx_byte = JID_TYPE;
          default:   tx_byte = JID_CAP;
        endcase
      end
      default:   tx_byte = DATA_PAD;
    endcase
    if (rb_mode)
    begin
      next_t.oe         = 1'b1;
      next_t.sr[TX_MSB] = !l.st_sync[ST_BUSY];
    end
    else if (!in_frame)
      next_t.oe = 1'b0;
    else
    begin
      case (l.phase)
        P_OUT_MEM, P_OUT_ST, P_OUT_ID, P_OUT_JID:
        begin
          next_t.oe = 1'b1;
          next_t.sr = (l.bit_cnt == BIT_FIRST) ? tx_byte : {t.sr[TX_MSB-1:0], 1'b0};
        end
        default:
          next_t.oe = 1'b0;
      endcase
    end
  end

  always_ff @(negedge sck or posedge select_n or negedge nrst)
  begin
    if (!nrst)
      t <= '0;
    else if (select_n)
      t <= '0;
    else
      t <= next_t;
  end

  assign serial_out    = t.sr[TX_MSB];
  assign serial_out_oe = t.oe;
  assign mem_rd_addr   = l.rd_addr;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_n_s = rst_pipe[1];

  // Link registers are read only after select_n has risen; the master leaves
  // the serial clock still then, so they are stable while sampled here.
  always_comb
  begin
    next_c    = c;
    frame_end = 1'b0;
    one       = (l.byte_cnt == LEN_ONE);
    c_addr    = l.addr[19:0];
    want      = 1'b0;
    want_kind = K_PROG;
    want_addr = c_addr;
    want_len  = LEN_PROG;
    blocked   = 1'b0;
    ok_aai_hit = prot_hit(c.level[2:0], c.ptr);
    if (ce)
    begin
      next_c.op_start = 1'b0;
      next_c.cs_meta  = select_n;
      next_c.cs_sync  = c.cs_meta;
      next_c.cs_last  = c.cs_sync;
      next_c.wp_meta  = write_protect_n;
      next_c.wp_sync  = c.wp_meta;
      next_c.tog_meta = l.frame_tog;
      next_c.tog_sync = c.tog_meta;
      frame_end = c.cs_sync && !c.cs_last && (c.tog_sync != c.tog_seen);
      if (frame_end)
        next_c.tog_seen = c.tog_sync;
      if (c.busy && mem_op_done)
      begin
        next_c.busy = 1'b0;
        if (c.auto_last)
        begin
          next_c.auto_inc    = 1'b0;
          next_c.write_latch = 1'b0;
          next_c.auto_last   = 1'b0;
        end
      end
      if (frame_end && l.bit_cnt == BIT_FIRST && !c.busy)
      begin
        if (c.auto_inc)
        begin
          if (l.opcode == OP_WR_DIS && one)
          begin
            next_c.write_latch = 1'b0;
            next_c.auto_inc    = 1'b0;
          end
          else if (l.opcode == OP_AUTO_INC && l.byte_cnt == LEN_AUTO_NEXT)
          begin
            if (ok_aai_hit)
            begin
              next_c.auto_inc    = 1'b0;
              next_c.write_latch = 1'b0;
            end
            else
            begin
              next_c.op        = '{kind: K_AUTO, addr: c.ptr, data: {l.d0, l.d1}};
              next_c.op_start  = 1'b1;
              next_c.busy      = 1'b1;
              next_c.ptr       = c.ptr + WORD_STEP;
              next_c.auto_last = (c.ptr == WORD_LAST);
            end
          end
        end
        else
        begin
          case (l.opcode)
            OP_WR_EN:    if (one) next_c.write_latch = 1'b1;
            OP_WR_DIS:   if (one) next_c.write_latch = 1'b0;
            OP_UNLOCK:   if (one) next_c.unlock = 1'b1;
            OP_BUSY_ON:  if (one) next_c.busy_out = 1'b1;
            OP_BUSY_OFF: if (one) next_c.busy_out = 1'b0;
            OP_STATUS_WRITE:
            begin
              if (l.byte_cnt == LEN_STATUS_WR && (c.write_latch || c.unlock))
              begin
                if (c.wp_sync || !c.protect_lock)
                begin
                  next_c.level        = l.d1[ST_LVL_HI:ST_LVL_LO];
                  next_c.protect_lock = l.d1[ST_LOCK];
                end
                next_c.write_latch = 1'b0;
                next_c.unlock      = 1'b0;
              end
            end
            OP_PROG:
            begin
              want = 1'b1;
            end
            OP_SECT:
            begin
              want      = 1'b1;
              want_kind = K_SECT;
              want_addr = c_addr & MASK_SECT;
              want_len  = LEN_ERASE;
            end
            OP_BLK32:
            begin
              want      = 1'b1;
              want_kind = K_BLK32;
              want_addr = c_addr & MASK_BLK32;
              want_len  = LEN_ERASE;
            end
            OP_BLK64:
            begin
              want      = 1'b1;
              want_kind = K_BLK64;
              want_addr = c_addr & MASK_BLK64;
              want_len  = LEN_ERASE;
            end
            OP_CHIP_A, OP_CHIP_B:
            begin
              want      = 1'b1;
              want_kind = K_CHIP;
              want_len  = LEN_ONE;
            end
            OP_AUTO_INC:
            begin
              want      = 1'b1;
              want_kind = K_AUTO;
              want_addr = c_addr & MASK_EVEN;
              want_len  = LEN_AUTO_FIRST;
            end
            default:
              want = 1'b0;
          endcase
          if (want_kind == K_CHIP)
            blocked = (c.level != LEVEL_NONE);
          else
            blocked = prot_hit(c.level[2:0], want_addr);
          if (want && l.byte_cnt == want_len && c.write_latch && !blocked)
          begin
            next_c.op       = '{kind: want_kind, addr: want_addr,
                                data: (want_kind == K_AUTO) ? {l.d0, l.d1} : {DATA_PAD, l.d1}};
            next_c.op_start = 1'b1;
            next_c.busy     = 1'b1;
            if (want_kind == K_AUTO)
            begin
              next_c.auto_inc  = 1'b1;
              next_c.ptr       = want_addr + WORD_STEP;
              next_c.auto_last = (want_addr == WORD_LAST);
            end
            else
              next_c.write_latch = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      c              <= '0;
      c.cs_meta      <= 1'b1;
      c.cs_sync      <= 1'b1;
      c.cs_last      <= 1'b1;
      c.level        <= LEVEL_RESET;
      c.protect_lock <= 1'b0;
    end
    else
      c <= next_c;
  end

  assign mem_op       = c.op;
  assign mem_op_start = c.op_start;

  a_busy_on_start: assert property (@(posedge mclk) disable iff (!rst_n_s)
    c.op_start |-> c.busy) else $error("start without busy");
  a_busy_done: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (ce && c.busy && mem_op_done) |=> !c.busy) else $error("busy stuck");
  a_busy_no_start: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (ce && c.busy && !mem_op_done) |=> !c.op_start) else $error("start while busy");
  a_chip_guard: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (c.op_start && c.op.kind == K_CHIP) |-> c.level == LEVEL_NONE)
    else $error("chip erase while protected");
  a_prot_range: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (c.op_start && c.op.kind != K_CHIP) |-> !prot_hit(c.level[2:0], c.op.addr))
    else $error("write into protected range");
  a_latch_needed: assert property (@(posedge mclk) disable iff (!rst_n_s)
    c.op_start |-> $past(c.write_latch)) else $error("write without latch");
  a_latch_cleared: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (c.op_start && c.op.kind != K_AUTO) |-> !c.write_latch)
    else $error("latch kept after write");
  a_lock_hold: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (!c.wp_sync && c.protect_lock) |=> $stable(c.level) && c.protect_lock)
    else $error("locked protection changed");
  a_auto_latch: assert property (@(posedge mclk) disable iff (!rst_n_s)
    c.auto_inc |-> c.write_latch) else $error("auto mode without latch");
  a_power_up: assert property (@(posedge mclk) disable iff (!rst_n_s)
    $rose(rst_n_s) |-> (c.level == LEVEL_RESET) && !c.protect_lock)
    else $error("bad power-up protection");

endmodule : sfc_front_end

`default_nettype wire

// ==== src/sfc_pkg.sv ====
// Constants, opcodes and carrier types of the serial flash command front end.
// Assumes a 20-bit byte-addressed memory core behind the block.
package sfc_pkg;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PROG         = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WR_DIS       = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_WR_EN        = 8'h06;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_SECT         = 8'h20;
  localparam logic [7:0] OP_UNLOCK       = 8'h50;
  localparam logic [7:0] OP_BLK32        = 8'h52;
  localparam logic [7:0] OP_CHIP_A       = 8'h60;
  localparam logic [7:0] OP_BUSY_ON      = 8'h70;
  localparam logic [7:0] OP_BUSY_OFF     = 8'h80;
  localparam logic [7:0] OP_ID_A         = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID     = 8'h9f;
  localparam logic [7:0] OP_ID_B         = 8'hab;
  localparam logic [7:0] OP_AUTO_INC     = 8'had;
  localparam logic [7:0] OP_CHIP_B       = 8'hc7;
  localparam logic [7:0] OP_BLK64        = 8'hd8;
  localparam logic [7:0] DATA_PAD        = 8'hff;
  // Byte counts of whole frames, opcode included.
  localparam logic [2:0] LEN_ZERO        = 3'h0;
  localparam logic [2:0] LEN_ONE         = 3'h1;
  localparam logic [2:0] LEN_STATUS_WR   = 3'h2;
  localparam logic [2:0] LEN_AUTO_NEXT   = 3'h3;
  localparam logic [2:0] LEN_ERASE       = 3'h4;
  localparam logic [2:0] LEN_PROG        = 3'h5;
  localparam logic [2:0] LEN_AUTO_FIRST  = 3'h6;
  localparam logic [2:0] LEN_MAX         = 3'h7;
  localparam logic [2:0] ADDR_LAST_BYTE  = 3'h3;
  localparam logic [2:0] BIT_FIRST       = 3'h0;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_STEP        = 3'h1;
  localparam int         ST_BUSY         = 0;
  localparam int         ST_LATCH        = 1;
  localparam int         ST_LVL_LO       = 2;
  localparam int         ST_LVL_HI       = 5;
  localparam int         ST_AUTO         = 6;
  localparam int         ST_LOCK         = 7;
  localparam int         SY_BUSY_OUT     = 8;
  localparam int         SYNC_W          = 9;
  localparam int         TX_MSB          = 7;
  localparam logic [3:0] LEVEL_RESET     = 4'hf;
  localparam logic [3:0] LEVEL_NONE      = 4'h0;
  localparam logic [2:0] LVL_OFF         = 3'h0;
  localparam logic [2:0] LVL_16          = 3'h1;
  localparam logic [2:0] LVL_8           = 3'h2;
  localparam logic [2:0] LVL_4           = 3'h3;
  localparam logic [2:0] LVL_2           = 3'h4;
  localparam logic [19:0] FLOOR_16       = 20'hf0000;
  localparam logic [19:0] FLOOR_8        = 20'he0000;
  localparam logic [19:0] FLOOR_4        = 20'hc0000;
  localparam logic [19:0] FLOOR_2        = 20'h80000;
  localparam logic [19:0] MASK_SECT      = 20'hff000;
  localparam logic [19:0] MASK_BLK32     = 20'hf8000;
  localparam logic [19:0] MASK_BLK64     = 20'hf0000;
  localparam logic [19:0] MASK_EVEN      = 20'hffffe;
  localparam logic [19:0] WORD_LAST      = 20'hffffe;
  localparam logic [19:0] WORD_STEP      = 20'h00002;
  localparam logic [19:0] ADDR_STEP      = 20'h00001;
  localparam logic [1:0]  JID_FIRST      = 2'h0;
  localparam logic [1:0]  JID_MID        = 2'h1;
  localparam logic [1:0]  JID_LAST       = 2'h2;
  localparam logic [1:0]  JID_STEP       = 2'h1;

  typedef enum logic [2:0] {K_PROG, K_AUTO, K_SECT, K_BLK32, K_BLK64, K_CHIP} sfc_kind_e;
  typedef enum logic [3:0] {P_OP, P_ADDR, P_DUMMY, P_IN, P_OUT_MEM, P_OUT_ST, P_OUT_ID,
                            P_OUT_JID, P_IGNORE} sfc_phase_e;

  typedef struct packed {
    sfc_kind_e   kind;
    logic [19:0] addr;
    logic [15:0] data;
  } sfc_op_s;

  typedef struct packed {
    sfc_phase_e        phase;
    logic [2:0]        bit_cnt;
    logic [6:0]        shreg;
    logic [2:0]        byte_cnt;
    logic [7:0]        opcode;
    logic [23:0]       addr;
    logic [7:0]        d0;
    logic [7:0]        d1;
    logic [19:0]       rd_addr;
    logic [1:0]        jid_idx;
    logic              frame_tog;
    logic [SYNC_W-1:0] st_meta;
    logic [SYNC_W-1:0] st_sync;
  } sfc_link_s;

  typedef struct packed {
    logic [TX_MSB:0] sr;
    logic            oe;
  } sfc_tx_s;

  typedef struct packed {
    logic        cs_meta;
    logic        cs_sync;
    logic        cs_last;
    logic        wp_meta;
    logic        wp_sync;
    logic        tog_meta;
    logic        tog_sync;
    logic        tog_seen;
    logic        busy;
    logic        write_latch;
    logic        unlock;
    logic        auto_inc;
    logic        auto_last;
    logic        busy_out;
    logic [3:0]  level;
    logic        protect_lock;
    logic [19:0] ptr;
    sfc_op_s     op;
    logic        op_start;
  } sfc_core_s;
endpackage : sfc_pkg

// ==== dv/sfc_spi_master.sv ====
// Serial bus master model that frames commands on select_n, clock idle low or,
// with mode3 set, idle high.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/100ps
`default_nettype none

module sfc_spi_master
(
  // Serial link pins
  output logic     sck,
  output logic     select_n,
  output logic     serial_in,
  input  wire logic serial_out
);
  logic mode3 = 1'b0;

  initial
  begin
    sck       = 1'b0;
    select_n  = 1'b1;
    serial_in = 1'b0;
  end

  // The clock stands at its idle level between frames, so the link sees an edge then only when mode3 changes.
  task automatic xfer(input int nbits, input logic [47:0] tx, input int nrx,
                      output logic [23:0] rx);
    rx = '0;
    sck = mode3;
    #62.5 select_n = 1'b0;
    for (int i = 0; i < nbits + 8 * nrx; i++)
    begin
      #62.5 sck = 1'b0;
      if (i < nbits) serial_in = tx[nbits-1-i];
      #62.5 sck = 1'b1;
      if (i >= nbits) rx = {rx[22:0], serial_out};
    end
    #62.5 sck = mode3;
    select_n = 1'b1;
    serial_in = ~serial_in;
    #600;
  endtask : xfer
endmodule : sfc_spi_master

`default_nettype wire

// ==== dv/serial_flash_command_front_end_tb.sv ====
// Self-checking bench: a row table of frames, then checks of the issued memory jobs.
// Assumes a memory core that returns the inverted low address byte and ends jobs late.
`timescale 1ns/100ps
`default_nettype none

module serial_flash_command_front_end_tb
  import sfc_pkg::*;
;
  typedef struct {logic wp; int nbits; logic [47:0] tx; int nrx; logic [23:0] exp;} sfc_row_s;
  logic        mclk = 1'b0;
  logic        nrst = 1'b1;
  logic        wp   = 1'b1;
  wire         sck, select_n, serial_in, serial_out, serial_out_oe;
  logic [19:0] mem_rd_addr;
  logic [7:0]  mem_rd_data;
  sfc_op_s     mem_op;
  logic        mem_op_start;
  logic        mem_op_done = 1'b0;
  int          busy_cnt = 0;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [23:0] rx;
  sfc_op_s     ops[$];
  sfc_row_s    rows[] = '{
    '{'1,8,48'h05,2,24'h3c3c}, '{'1,40,48'h0b0fffff00,2,24'h00ff},
    '{'1,32,48'h03000010,2,24'hefee}, '{'1,32,48'h90000000,1,24'h5a},
    '{'1,32,48'hab000001,2,24'ha5a5}, '{'1,8,48'h9f,3,24'h5a3cc3},
    '{'1,8,48'h06,0,'0}, '{'1,8,48'h05,1,24'h3e}, '{'1,8,48'h04,0,'0},
    '{'1,8,48'h05,1,24'h3c}, '{'1,8,48'h60,0,'0}, '{'1,8,48'h06,0,'0},
    '{'1,16,48'h0100,0,'0}, '{'1,8,48'h05,1,24'h00}, '{'1,8,48'h06,0,'0},
    '{'1,8,48'hc7,0,'0}, '{'1,8,48'h05,1,24'h01}, '{'1,8,48'h06,0,'0},
    '{'1,0,'0,0,'0}, '{'1,8,48'h05,1,24'h00}, '{'1,8,48'h06,0,'0},
    '{'1,16,48'h0184,0,'0}, '{'1,8,48'h05,1,24'h84}, '{'0,8,48'h06,0,'0},
    '{'0,16,48'h0100,0,'0}, '{'0,8,48'h05,1,24'h84}, '{'1,8,48'h06,0,'0},
    '{'1,8,48'h60,0,'0}, '{'1,40,48'h020f123455,0,'0},
    '{'1,40,48'h0201234555,0,'0},
    '{'1,0,'0,0,'0}, '{'1,8,48'h06,0,'0}, '{'1,32,48'h200abcde,0,'0},
    '{'1,0,'0,0,'0}, '{'1,8,48'h06,0,'0}, '{'1,12,48'h020,0,'0},
    '{'1,8,48'h05,1,24'h86}, '{'1,8,48'hff,1,24'h00}, '{'1,8,48'h04,0,'0},
    '{'1,8,48'h50,0,'0}, '{'1,16,48'h0100,0,'0}, '{'1,8,48'h05,1,24'h00},
    '{'1,8,48'h06,0,'0}, '{'1,32,48'h520abcde,0,'0}, '{'1,0,'0,0,'0},
    '{'1,8,48'h06,0,'0}, '{'1,32,48'hd80abcde,0,'0}, '{'1,0,'0,0,'0},
    '{'1,8,48'h70,0,'0}, '{'1,8,48'h06,0,'0}, '{'1,48,48'had0001011122,0,'0},
    '{'1,8,48'h05,1,24'h00}, '{'1,0,'0,0,'0}, '{'1,8,48'h05,1,24'hff},
    '{'1,24,48'had3344,0,'0}, '{'1,0,'0,0,'0}, '{'1,8,48'h04,0,'0},
    '{'1,8,48'h80,0,'0}, '{'1,8,48'h05,1,24'h00}};

  sfc_front_end sfc_front_end_inst (.mclk(mclk), .ce(1'b1), .nrst(nrst), .sck(sck),
    .select_n(select_n), .serial_in(serial_in), .write_protect_n(wp),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_op(mem_op), .mem_op_start(mem_op_start),
    .mem_op_done(mem_op_done));
  sfc_spi_master sfc_spi_master_inst (.sck(sck), .select_n(select_n),
    .serial_in(serial_in), .serial_out(serial_out));

  assign mem_rd_data = ~mem_rd_addr[7:0];
  always #50 mclk = ~mclk;

  // Jobs end long after issue so that a status frame can see the busy bit.
  always @(negedge mclk)
  begin
    if (mem_op_start === 1'b1)
    begin
      ops.push_back(mem_op);
      busy_cnt <= 60;
    end
    else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    mem_op_done <= (busy_cnt == 1);
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    #1000000;
    n_fail++;
    final_report();
  end

  initial
  begin
    @(negedge mclk);
    nrst = 1'b0;
    @(negedge mclk);
    check("oe in reset", 24'(serial_out_oe), 24'h0);
    @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    foreach (rows[k])
    begin
      @(negedge mclk);
      wp = rows[k].wp;
      if (rows[k].nbits == 0) #8000;
      else sfc_spi_master_inst.xfer(rows[k].nbits, rows[k].tx, rows[k].nrx, rx);
      if (rows[k].nrx > 0) check("frame reply", rx, rows[k].exp);
    end
    sfc_spi_master_inst.mode3 = 1'b1;
    sfc_spi_master_inst.xfer(32, 48'h03000010, 2, rx);
    check("idle-high read", rx, 24'hefee);
    sfc_spi_master_inst.xfer(8, 48'h9f, 3, rx);
    check("idle-high id", rx, 24'h5a3cc3);
    #8000;
    check("job count", 24'(ops.size()), 24'h7);
    if (ops.size() == 7)
    begin
      check("blk32 kind", 24'(ops[3].kind), 24'(K_BLK32));
      check("blk32 addr", 24'(ops[3].addr), 24'ha8000);
      check("blk64 kind", 24'(ops[4].kind), 24'(K_BLK64));
      check("blk64 addr", 24'(ops[4].addr), 24'ha0000);
      check("auto kind", 24'(ops[5].kind), 24'(K_AUTO));
      check("auto addr", 24'(ops[5].addr), 24'h00100);
      check("auto data", 24'(ops[5].data), 24'h1122);
      check("auto next addr", 24'(ops[6].addr), 24'h00102);
      check("auto next data", 24'(ops[6].data), 24'h3344);
      check("erase kind", 24'(ops[0].kind), 24'(K_CHIP));
      check("prog addr", 24'(ops[1].addr), 24'h12345);
      check("prog data", 24'(ops[1].data), 24'hff55);
      check("sector kind", 24'(ops[2].kind), 24'(K_SECT));
      check("sector addr", 24'(ops[2].addr), 24'hab000);
    end
    final_report();
  end
endmodule : serial_flash_command_front_end_tb

`default_nettype wire
